// ### hdl/tx_ctrl_defs.vh
// constants for the transmitter wake-up, baud and synthesizer control core
`ifndef TX_CTRL_DEFS_VH
`define TX_CTRL_DEFS_VH

// sized at the 8 ns clock: 1.5 ms start-up, 2 us band settle
`define CLK_PERIOD_NS 8
`define OSC_START_CYCLES 18'h2DC6C
`define PD_TIMEOUT_CYCLES 17'h10000
`define BAND_SETTLE_CYCLES 9'h0FA

`define ADDR_CFG 4'h0
`define ADDR_BAUD 4'h1
`define ADDR_CMPV 4'h2
`define ADDR_PLL 4'h3
`define ADDR_DEV 4'h4
`define ADDR_GAUSS 4'h5
`define ADDR_STATUS 4'h6
`define ADDR_BAND 4'h7
`define ADDR_TEMP_LO 4'h8
`define ADDR_TEMP_HI 4'h9

`define CFG_HCLK 1:0
`define CFG_MASH3 2
`define CFG_DIV 4:3
`define DIV_NONE 2'h3
`define BAUD_PSC 2:0
`define BAUD_ASC 4:3
`define BAUD_HSRC 5
`define PLL_EN 0
`define PLL_PA 1
`define PLL_CP 5:2

`define RST_CFG 8'h01
`define RST_BAUD 8'h00
`define RST_CMPV 8'h0F
`define RST_PLL 8'h20
`define RST_DEV 8'h10
`define RST_GAUSS 4'h0

`define HCLK_OFF 2'h0
`define HCLK_ALWAYS 2'h1
`define HCLK_TX 2'h2

`define OP_WRITE 2'h0
`define OP_READ 2'h1
`define OP_TX 2'h2

`define PATH_ASYNC 2'h0
`define PATH_SYNC 2'h1
`define PATH_MANCH 2'h2

`endif

// ### hdl/ser_rx_shift.v
// byte assembler for sampled serial bits, msb first
`timescale 1ns/100ps
module ser_rx_shift (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire clear_i,
  input wire sample_i,
  input wire bit_i,
  output reg [7:0] byte_o,
  output reg byte_valid_o
);
  reg [6:0] shift_ff;
  reg [2:0] cnt_ff;

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_ff <= 7'h00;
      cnt_ff <= 3'h0;
      byte_o <= 8'h00;
      byte_valid_o <= 1'b0;
    end else begin
      byte_valid_o <= 1'b0;
      if (clear_i) begin
        cnt_ff <= 3'h0;
      end else if (sample_i) begin
        shift_ff <= {shift_ff[5:0], bit_i};
        cnt_ff <= cnt_ff + 3'h1;
        if (cnt_ff == 3'h7) begin
          byte_o <= {shift_ff, bit_i};
          byte_valid_o <= 1'b1;
        end
      end
    end
  end
endmodule

// ### hdl/tx_baud_gen.v
// baud rate generator: prescaler, compare timer, postscaler, host clock
`timescale 1ns/100ps
module tx_baud_gen (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire resync_i,
  input wire [2:0] prescale_exponent_i,
  input wire [1:0] postscale_exponent_i,
  input wire [7:0] compare_value_i,
  input wire host_src_baud_i,
  input wire host_clk_en_i,
  output reg baud_clk_o,
  output reg baud_rise_o,
  output reg host_clock_out_o
);
  reg [6:0] pre_cnt_ff;
  reg [7:0] cmp_cnt_ff;
  reg [2:0] post_cnt_ff;
  reg pre_clk_ff;

  wire [6:0] pre_max = (7'h01 << prescale_exponent_i) - 7'h01;
  wire [2:0] post_max = (3'h1 << postscale_exponent_i) - 3'h1;
  wire pre_tick = (pre_cnt_ff == pre_max);
  wire cmp_tick = pre_tick & (cmp_cnt_ff == compare_value_i);
  wire post_tick = cmp_tick & (post_cnt_ff == post_max);
  wire nxt_pre_clk = pre_clk_ff ^ pre_tick;
  // toggling on the last stage gives the 50 percent duty
  wire nxt_baud = baud_clk_o ^ post_tick;

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_cnt_ff <= 7'h00;
      cmp_cnt_ff <= 8'h00;
      post_cnt_ff <= 3'h0;
      pre_clk_ff <= 1'b0;
      baud_clk_o <= 1'b0;
      baud_rise_o <= 1'b0;
      host_clock_out_o <= 1'b0;
    end else if (resync_i) begin
      pre_cnt_ff <= 7'h00;
      cmp_cnt_ff <= 8'h00;
      post_cnt_ff <= 3'h0;
      pre_clk_ff <= 1'b0;
      baud_clk_o <= 1'b0;
      baud_rise_o <= 1'b0;
      host_clock_out_o <= 1'b0;
    end else begin
      pre_cnt_ff <= pre_tick ? 7'h00 : pre_cnt_ff + 7'h01;
      if (pre_tick) begin
        cmp_cnt_ff <= cmp_tick ? 8'h00 : cmp_cnt_ff + 8'h01;
      end
      if (cmp_tick) begin
        post_cnt_ff <= post_tick ? 3'h0 : post_cnt_ff + 3'h1;
      end
      pre_clk_ff <= nxt_pre_clk;
      baud_clk_o <= nxt_baud;
      baud_rise_o <= post_tick & ~baud_clk_o;
      host_clock_out_o <= host_clk_en_i & (host_src_baud_i ? nxt_baud : nxt_pre_clk);
    end
  end
endmodule

// ### hdl/tx_ctrl_core.v
// transmitter control core: wake-up, serial link, baud control, synthesizer control
`timescale 1ns/100ps
`include "tx_ctrl_defs.vh"
module tx_ctrl_core #(
  parameter [16:0] PD_CYCLES = `PD_TIMEOUT_CYCLES,
  parameter [17:0] OSC_CYCLES = `OSC_START_CYCLES
) (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire [3:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  input wire ser_en_i,
  input wire ser_clk_i,
  input wire ser_data_i,
  output reg ser_data_o,
  output reg ser_data_oe_o,
  input wire supply_low_i,
  input wire pll_lock_i,
  input wire vco_fast_i,
  input wire [9:0] temp_adc_i,
  output reg osc_start_o,
  output reg osc_ready_o,
  output reg power_down_o,
  output wire host_clock_out_o,
  output wire baud_clk_o,
  output reg tx_data_o,
  output reg pll_en_o,
  output reg pa_on_o,
  output reg [3:0] auto_band_select_o,
  output reg [1:0] vco_div_o,
  output reg mash3_o,
  output reg [3:0] charge_pump_o,
  output reg [7:0] deviation_o,
  output reg [3:0] gauss_o,
  output reg pll_locked_o
);
  localparam [3:0] S_CMD = 4'b0001;
  localparam [3:0] S_WR = 4'b0010;
  localparam [3:0] S_RD = 4'b0100;
  localparam [3:0] S_TX = 4'b1000;
  localparam [2:0] B_IDLE = 3'b001;
  localparam [2:0] B_SEARCH = 3'b010;
  localparam [2:0] B_DONE = 3'b100;
  localparam [8:0] BAND_WAIT = `BAND_SETTLE_CYCLES;

  // pin synchronisers; logic reads sync_ff and the en_d_ff/sclk_d_ff edge flops, never meta_ff
  wire [5:0] async_in = {vco_fast_i, pll_lock_i, supply_low_i, ser_data_i, ser_clk_i, ser_en_i};
  reg [5:0] meta_ff;
  reg [5:0] sync_ff;
  reg en_d_ff;
  reg sclk_d_ff;
  wire en_s = sync_ff[0];
  wire sclk_s = sync_ff[1];
  wire sdat_s = sync_ff[2];
  wire low_s = sync_ff[3];
  wire lock_s = sync_ff[4];
  wire fast_s = sync_ff[5];
  wire en_rise = en_s & ~en_d_ff;
  wire sclk_rise = sclk_s & ~sclk_d_ff;
  wire sclk_fall = ~sclk_s & sclk_d_ff;

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff <= 6'h00;
      sync_ff <= 6'h00;
      en_d_ff <= 1'b0;
      sclk_d_ff <= 1'b0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
      en_d_ff <= sync_ff[0];
      sclk_d_ff <= sync_ff[1];
    end
  end

  // wake-up, power down timer and oscillator start
  reg pd_ff;
  reg [16:0] pd_cnt_ff;
  reg [17:0] osc_cnt_ff;
  reg edge_pol_ff;
  reg wake_data_ff;
  wire wake = en_rise & pd_ff;
  wire sample_edge = edge_pol_ff ? sclk_rise : sclk_fall;
  wire drive_edge = edge_pol_ff ? sclk_fall : sclk_rise;

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pd_ff <= 1'b1;
      pd_cnt_ff <= 17'h00000;
      osc_cnt_ff <= 18'h00000;
      edge_pol_ff <= 1'b0;
      wake_data_ff <= 1'b0;
      osc_start_o <= 1'b0;
      osc_ready_o <= 1'b0;
      power_down_o <= 1'b1;
    end else begin
      if (en_s) begin
        pd_cnt_ff <= 17'h00000;
      end else if (pd_cnt_ff != PD_CYCLES) begin
        pd_cnt_ff <= pd_cnt_ff + 17'h00001;
      end
      if (!en_s && pd_cnt_ff == PD_CYCLES - 17'h00001) begin
        pd_ff <= 1'b1;
        power_down_o <= 1'b1;
        osc_start_o <= 1'b0;
        osc_ready_o <= 1'b0;
      end else if (wake) begin
        pd_ff <= 1'b0;
        power_down_o <= 1'b0;
        osc_start_o <= 1'b1;
        osc_cnt_ff <= 18'h00000;
        edge_pol_ff <= sclk_s;
        wake_data_ff <= sdat_s;
      end else if (osc_start_o && !osc_ready_o) begin
        osc_cnt_ff <= osc_cnt_ff + 18'h00001;
        // settle window counted at the longest start-up time
        if (osc_cnt_ff == OSC_CYCLES - 18'h00001) begin
          osc_ready_o <= 1'b1;
        end
      end
    end
  end

  // configuration registers
  reg [7:0] cfg_ff;
  reg [7:0] baud_cfg_ff;
  reg [7:0] cmpv_ff;
  reg [7:0] pll_ff;
  reg [9:0] temp_ff;
  reg [3:0] ser_state_ff;
  reg [3:0] ser_addr_ff;
  reg ser_wr_ff;
  reg [7:0] ser_wdata_ff;
  reg tx_active_ff;
  reg resync_ff;
  reg [2:0] band_state_ff;
  wire wr_hit = ser_wr_ff | reg_wr_i;
  // serial write wins a collision with the parallel port
  wire [3:0] wr_addr = ser_wr_ff ? ser_addr_ff : reg_addr_i;
  wire [7:0] wr_data = ser_wr_ff ? ser_wdata_ff : reg_wdata_i;

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_ff <= `RST_CFG;
      baud_cfg_ff <= `RST_BAUD;
      cmpv_ff <= `RST_CMPV;
      pll_ff <= `RST_PLL;
      deviation_o <= `RST_DEV;
      gauss_o <= `RST_GAUSS;
    end else if (wr_hit) begin
      if (wr_addr == `ADDR_CFG) begin
        cfg_ff <= wr_data;
      end else if (wr_addr == `ADDR_BAUD) begin
        baud_cfg_ff <= wr_data;
      end else if (wr_addr == `ADDR_CMPV) begin
        cmpv_ff <= wr_data;
      end else if (wr_addr == `ADDR_PLL) begin
        pll_ff <= wr_data;
      end else if (wr_addr == `ADDR_DEV) begin
        deviation_o <= wr_data;
      end else if (wr_addr == `ADDR_GAUSS) begin
        gauss_o <= wr_data[3:0];
      end
    end
  end

  function [7:0] read_mux;
    input [3:0] addr;
    begin
      if (addr == `ADDR_CFG) begin
        read_mux = cfg_ff;
      end else if (addr == `ADDR_BAUD) begin
        read_mux = baud_cfg_ff;
      end else if (addr == `ADDR_CMPV) begin
        read_mux = cmpv_ff;
      end else if (addr == `ADDR_PLL) begin
        read_mux = pll_ff;
      end else if (addr == `ADDR_DEV) begin
        read_mux = deviation_o;
      end else if (addr == `ADDR_GAUSS) begin
        read_mux = {4'h0, gauss_o};
      end else if (addr == `ADDR_STATUS) begin
        read_mux = {pd_ff, edge_pol_ff, osc_ready_o, pll_locked_o, band_state_ff[2], wake_data_ff,
                    tx_active_ff, low_s};
      end else if (addr == `ADDR_BAND) begin
        read_mux = {4'h0, auto_band_select_o};
      end else if (addr == `ADDR_TEMP_LO) begin
        read_mux = temp_ff[7:0];
      end else if (addr == `ADDR_TEMP_HI) begin
        read_mux = {6'h00, temp_ff[9:8]};
      end else begin
        read_mux = 8'h00;
      end
    end
  endfunction

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= reg_rd_i ? read_mux(reg_addr_i) : 8'h00;
    end
  end

  // serial link: command byte, then write bytes, read bytes or transmit bits
  wire [7:0] rx_byte;
  wire rx_valid;
  reg [1:0] path_ff;
  reg [7:0] rd_shift_ff;
  reg [2:0] rd_cnt_ff;
  reg tx_bit_ff;

  ser_rx_shift u_rx (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .clear_i(~en_s),
    .sample_i(sample_edge & ~ser_state_ff[3] & ~ser_state_ff[2]),
    .bit_i(sdat_s),
    .byte_o(rx_byte),
    .byte_valid_o(rx_valid)
  );

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ser_state_ff <= S_CMD;
      ser_addr_ff <= 4'h0;
      ser_wr_ff <= 1'b0;
      ser_wdata_ff <= 8'h00;
      path_ff <= `PATH_ASYNC;
      rd_shift_ff <= 8'h00;
      rd_cnt_ff <= 3'h0;
      tx_bit_ff <= 1'b0;
      tx_active_ff <= 1'b0;
      ser_data_o <= 1'b0;
      ser_data_oe_o <= 1'b0;
    end else begin
      ser_wr_ff <= 1'b0;
      if (!en_s || pd_ff) begin
        // enable low ends any transaction
        ser_state_ff <= S_CMD;
        ser_data_oe_o <= 1'b0;
        tx_active_ff <= 1'b0;
        rd_cnt_ff <= 3'h0;
      end else begin
        case (ser_state_ff)
          S_CMD: begin
            if (rx_valid) begin
              ser_addr_ff <= rx_byte[3:0];
              if (rx_byte[7:6] == `OP_WRITE) begin
                ser_state_ff <= S_WR;
              end else if (rx_byte[7:6] == `OP_READ) begin
                rd_shift_ff <= read_mux(rx_byte[3:0]);
                ser_state_ff <= S_RD;
              end else if (rx_byte[7:6] == `OP_TX && osc_ready_o) begin
                path_ff <= rx_byte[1:0];
                tx_active_ff <= 1'b1;
                ser_state_ff <= S_TX;
              end
            end
          end
          S_WR: begin
            if (rx_valid) begin
              ser_wr_ff <= 1'b1;
              ser_wdata_ff <= rx_byte;
            end
            if (ser_wr_ff) begin
              ser_addr_ff <= ser_addr_ff + 4'h1;
            end
          end
          S_RD: begin
            if (drive_edge) begin
              ser_data_oe_o <= 1'b1;
              ser_data_o <= rd_shift_ff[7];
              rd_cnt_ff <= rd_cnt_ff + 3'h1;
              if (rd_cnt_ff == 3'h7) begin
                ser_addr_ff <= ser_addr_ff + 4'h1;
                rd_shift_ff <= read_mux(ser_addr_ff + 4'h1);
              end else begin
                rd_shift_ff <= {rd_shift_ff[6:0], 1'b0};
              end
            end
          end
          S_TX: begin
            if (sample_edge) begin
              tx_bit_ff <= sdat_s;
            end
          end
          default: begin
            ser_state_ff <= S_CMD;
          end
        endcase
      end
    end
  end

  // transmit data path selection
  wire baud_rise;
  reg tx_sync_ff;
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_sync_ff <= 1'b0;
      tx_data_o <= 1'b0;
    end else begin
      if (baud_rise) begin
        tx_sync_ff <= tx_bit_ff;
      end
      if (!tx_active_ff) begin
        tx_data_o <= 1'b0;
      end else if (path_ff == `PATH_ASYNC) begin
        tx_data_o <= tx_bit_ff;
      end else if (path_ff == `PATH_SYNC) begin
        tx_data_o <= tx_sync_ff;
      end else begin
        tx_data_o <= tx_sync_ff ^ baud_clk_o;
      end
    end
  end

  // host clock enable and baud re-phasing
  reg host_en_ff;
  reg tx_active_d_ff;
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      host_en_ff <= 1'b0;
      tx_active_d_ff <= 1'b0;
      resync_ff <= 1'b0;
    end else begin
      tx_active_d_ff <= tx_active_ff;
      resync_ff <= (wr_hit && (wr_addr == `ADDR_BAUD || wr_addr == `ADDR_CMPV || wr_addr == `ADDR_CFG)) ||
                   (tx_active_ff && !tx_active_d_ff);
      host_en_ff <= osc_ready_o && wake_data_ff && ((cfg_ff[`CFG_HCLK] == `HCLK_ALWAYS) ||
                    (cfg_ff[`CFG_HCLK] == `HCLK_TX && tx_active_ff));
    end
  end

  tx_baud_gen u_baud (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .resync_i(resync_ff),
    .prescale_exponent_i(baud_cfg_ff[`BAUD_PSC]),
    .postscale_exponent_i(baud_cfg_ff[`BAUD_ASC]),
    .compare_value_i(cmpv_ff),
    .host_src_baud_i(baud_cfg_ff[`BAUD_HSRC]),
    .host_clk_en_i(host_en_ff),
    .baud_clk_o(baud_clk_o),
    .baud_rise_o(baud_rise),
    .host_clock_out_o(host_clock_out_o)
  );

  // synthesizer control: band search, lock, divider, amplifier guard, temperature
  reg [3:0] trial_ff;
  reg [8:0] wait_ff;
  reg pll_req_d_ff;
  wire pll_req = pll_ff[`PLL_EN] & osc_ready_o;

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      band_state_ff <= B_IDLE;
      trial_ff <= 4'h0;
      wait_ff <= 9'h000;
      pll_req_d_ff <= 1'b0;
      auto_band_select_o <= 4'h0;
    end else begin
      pll_req_d_ff <= pll_req;
      case (band_state_ff)
        B_IDLE: begin
          if (pll_req && !pll_req_d_ff) begin
            band_state_ff <= B_SEARCH;
            trial_ff <= 4'h8;
            auto_band_select_o <= 4'h8;
            wait_ff <= 9'h000;
          end
        end
        B_SEARCH: begin
          if (!pll_req) begin
            band_state_ff <= B_IDLE;
          end else if (wait_ff != BAND_WAIT - 9'h001) begin
            wait_ff <= wait_ff + 9'h001;
          end else begin
            wait_ff <= 9'h000;
            // binary search, one comparator decision per band bit
            trial_ff <= trial_ff >> 1;
            auto_band_select_o <= (fast_s ? auto_band_select_o & ~trial_ff : auto_band_select_o) |
                                  (trial_ff >> 1);
            if (trial_ff == 4'h1) begin
              band_state_ff <= B_DONE;
            end
          end
        end
        B_DONE: begin
          if (!pll_req) begin
            band_state_ff <= B_IDLE;
          end
        end
        default: begin
          band_state_ff <= B_IDLE;
        end
      endcase
    end
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pll_en_o <= 1'b0;
      pa_on_o <= 1'b0;
      pll_locked_o <= 1'b0;
      vco_div_o <= 2'h0;
      mash3_o <= 1'b0;
      charge_pump_o <= 4'h0;
      temp_ff <= 10'h000;
    end else begin
      pll_en_o <= pll_req;
      pa_on_o <= pll_req & pll_ff[`PLL_PA] & ~low_s;
      // lock drops with the enable so it never outlives the pll
      pll_locked_o <= band_state_ff[2] & lock_s & pll_req;
      // code 3 has no divider; the last legal choice stays
      if (cfg_ff[`CFG_DIV] != `DIV_NONE) begin
        vco_div_o <= cfg_ff[`CFG_DIV];
      end
      mash3_o <= cfg_ff[`CFG_MASH3];
      charge_pump_o <= pll_ff[`PLL_CP];
      // converter result only trusted in clock enable mode
      if (osc_ready_o && !pll_ff[`PLL_EN] && !pll_ff[`PLL_PA]) begin
        temp_ff <= temp_adc_i;
      end
    end
  end
endmodule

// ### testbench/tx_ctrl_core_sva.sv
// assertion checker for the transmitter control core
`timescale 1ns/100ps
module tx_ctrl_core_sva #(
  parameter [16:0] PD_CYCLES = 17'h10000,
  parameter [17:0] OSC_CYCLES = 18'h2DC6C
) (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire reg_rd_i,
  input wire [7:0] reg_rdata_o,
  input wire ser_en_i,
  input wire supply_low_i,
  input wire osc_start_o,
  input wire osc_ready_o,
  input wire power_down_o,
  input wire host_clock_out_o,
  input wire pll_en_o,
  input wire pa_on_o,
  input wire [1:0] vco_div_o,
  input wire pll_locked_o
);
  reg [17:0] low_ff;
  reg [17:0] osc_ff;
  // saturating, so a long idle never wraps into a false early count
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_ff <= 18'h0;
      osc_ff <= 18'h0;
    end else begin
      low_ff <= ser_en_i ? 18'h0 : low_ff + {17'h0, ~&low_ff};
      osc_ff <= osc_start_o ? osc_ff + 18'h1 : 18'h0;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_wake;
    power_down_o ##0 $rose(ser_en_i);
  endsequence
  sequence s_supply_low;
    supply_low_i [*5];
  endsequence
  a_wake_osc_start: assert property (s_wake |-> ##[1:8] osc_start_o)
    else $error("oscillator not started after wake");
  a_osc_settle_time: assert property ($rose(osc_ready_o) |->
    (osc_ff >= OSC_CYCLES - 2) && (osc_ff <= OSC_CYCLES + 2))
    else $error("oscillator ready at wrong time");
  a_ready_needs_start: assert property (osc_ready_o |-> osc_start_o)
    else $error("ready without oscillator running");
  a_pa_supply_off: assert property (s_supply_low |-> !pa_on_o)
    else $error("amplifier on during low supply");
  a_pa_needs_osc: assert property (pa_on_o |-> pll_en_o && $past(osc_ready_o))
    else $error("amplifier on before oscillator or pll");
  a_pd_timeout: assert property (low_ff > PD_CYCLES + 8 |-> power_down_o)
    else $error("no power down after long enable low");
  a_pd_not_early: assert property ($rose(power_down_o) |-> low_ff >= PD_CYCLES)
    else $error("power down entered too early");
  a_host_clk_idle: assert property ($rose(host_clock_out_o) |-> $past(osc_ready_o, 2))
    else $error("host clock before oscillator ready");
  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data outside read cycle");
  a_div_legal: assert property (vco_div_o != 2'h3)
    else $error("illegal divider code");
  a_lock_needs_pll: assert property (pll_locked_o |-> pll_en_o)
    else $error("lock reported with pll off");
endmodule

bind tx_ctrl_core tx_ctrl_core_sva #(.PD_CYCLES(PD_CYCLES), .OSC_CYCLES(OSC_CYCLES)) sva_i (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .ser_en_i(ser_en_i), .supply_low_i(supply_low_i), .osc_start_o(osc_start_o), .osc_ready_o(osc_ready_o),
  .power_down_o(power_down_o), .host_clock_out_o(host_clock_out_o), .pll_en_o(pll_en_o), .pa_on_o(pa_on_o),
  .vco_div_o(vco_div_o), .pll_locked_o(pll_locked_o));

// ### testbench/host_mcu_model.sv
// serial link master model standing in for the microcontroller
`timescale 1ns/100ps
module host_mcu_model #(
  parameter HP = 8
) (
  input wire sys_clk_i,
  input wire line_i,
  output reg ser_en_o,
  output reg ser_clk_o,
  output reg ser_data_o
);
  reg idle_ff;
  initial begin
    ser_en_o = 1'b0;
    ser_clk_o = 1'b0;
    ser_data_o = 1'b0;
    idle_ff = 1'b0;
  end
  task automatic half;
    repeat (HP) @(posedge sys_clk_i);
  endtask
  task automatic wake(input logic lvl, input logic dat);
    half;
    idle_ff = lvl;
    ser_clk_o <= lvl;
    ser_data_o <= dat;
    half;
    ser_en_o <= 1'b1;
    half;
  endtask
  // drive on the transfer edge, device samples on the idle-level edge
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      ser_clk_o <= ~idle_ff;
      ser_data_o <= b[i];
      half;
      ser_clk_o <= idle_ff;
      half;
    end
  endtask
  // line released: keep toggling so a stale level never reads as data
  task automatic read_byte(output logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      ser_clk_o <= ~idle_ff;
      ser_data_o <= ~ser_data_o;
      half;
      b = {b[6:0], line_i};
      ser_clk_o <= idle_ff;
      half;
    end
  endtask
  // low pulse longer than one serial clock, far shorter than power down
  task automatic restart;
    ser_en_o <= 1'b0;
    repeat (3) half;
    ser_en_o <= 1'b1;
    half;
  endtask
  task automatic stop;
    ser_en_o <= 1'b0;
    half;
  endtask
endmodule

// ### testbench/tb_tx_wakeup_and_baud_control.sv
// self-checking bench for the transmitter control core
`timescale 1ns/100ps
`include "tx_ctrl_defs.vh"
module tb_tx_wakeup_and_baud_control;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic supply_low_i = 1'b0;
  logic pll_lock_i = 1'b0;
  logic vco_fast_i = 1'b0;
  logic [9:0] temp_adc_i = 10'h000;
  wire [7:0] reg_rdata_o;
  wire [7:0] deviation_o;
  wire [3:0] auto_band_select_o;
  wire [1:0] vco_div_o;
  wire [3:0] charge_pump_o;
  wire ser_en_i, ser_clk_i, mcu_data, ser_data_o, ser_data_oe_o, osc_start_o, osc_ready_o, power_down_o;
  wire host_clock_out_o, baud_clk_o, pa_on_o, mash3_o, pll_locked_o, tx_data_o;
  wire ser_data_i = ser_data_oe_o ? ser_data_o : mcu_data;
  int mismatches = 0;
  int checked = 0;
  tx_ctrl_core #(.PD_CYCLES(17'h40), .OSC_CYCLES(18'h32)) DUT (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .ser_en_i(ser_en_i), .ser_clk_i(ser_clk_i), .ser_data_i(ser_data_i),
    .ser_data_o(ser_data_o), .ser_data_oe_o(ser_data_oe_o), .supply_low_i(supply_low_i),
    .pll_lock_i(pll_lock_i), .vco_fast_i(vco_fast_i), .temp_adc_i(temp_adc_i), .osc_start_o(osc_start_o),
    .osc_ready_o(osc_ready_o), .power_down_o(power_down_o), .host_clock_out_o(host_clock_out_o),
    .baud_clk_o(baud_clk_o), .tx_data_o(tx_data_o), .pll_en_o(), .pa_on_o(pa_on_o),
    .auto_band_select_o(auto_band_select_o), .vco_div_o(vco_div_o), .mash3_o(mash3_o),
    .charge_pump_o(charge_pump_o),
    .deviation_o(deviation_o), .gauss_o(), .pll_locked_o(pll_locked_o));
  host_mcu_model #(.HP(8)) mcu (.sys_clk_i(sys_clk_i), .line_i(ser_data_i), .ser_en_o(ser_en_i),
    .ser_clk_o(ser_clk_i), .ser_data_o(mcu_data));
  initial forever #4 sys_clk_i = ~sys_clk_i;
  task automatic step;
    @(posedge sys_clk_i);
    #1;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o, e);
  endtask
  task automatic t_reset;
    rd_chk(`ADDR_CFG, `RST_CFG);
    rd_chk(`ADDR_BAUD, `RST_BAUD);
    rd_chk(`ADDR_CMPV, `RST_CMPV);
    rd_chk(`ADDR_PLL, `RST_PLL);
    rd_chk(4'hA, 8'h00);
    wr(`ADDR_DEV, 8'h5A);
    rd_chk(`ADDR_DEV, 8'h5A);
    chk({deviation_o[7:1], power_down_o}, 8'h5B);
    $display("t_reset done");
  endtask
  task automatic t_wake;
    logic [7:0] n;
    logic h;
    n = 8'h00;
    mcu.wake(1'b0, 1'b1);
    for (int i = 0; i < 20 && osc_start_o !== 1'b1; i++) step;
    chk(osc_start_o, 1'b1);
    for (int i = 0; i < 80 && osc_ready_o !== 1'b1; i++) step;
    chk({power_down_o, osc_ready_o}, 8'h01);
    rd_chk(`ADDR_STATUS, 8'h24);
    h = host_clock_out_o;
    for (int i = 0; i < 64; i++) begin
      step;
      if (host_clock_out_o !== h) n++;
      h = host_clock_out_o;
    end
    chk(n != 8'h00, 8'h01);
    $display("t_wake done");
  endtask
  task automatic t_serial;
    logic [7:0] b;
    mcu.send_byte({`OP_WRITE, 2'b00, `ADDR_BAUD});
    mcu.send_byte(8'h01);
    mcu.send_byte(8'h02);
    mcu.restart;
    rd_chk(`ADDR_BAUD, 8'h01);
    rd_chk(`ADDR_CMPV, 8'h02);
    mcu.send_byte({`OP_READ, 2'b00, `ADDR_BAUD});
    mcu.read_byte(b);
    chk(b, 8'h01);
    mcu.read_byte(b);
    chk(b, 8'h02);
    mcu.restart;
    $display("t_serial done");
  endtask
  // expected period 2^(1+0+1)*(2+1) = 12 cycles, split evenly
  task automatic t_baud;
    logic [7:0] hi;
    logic [7:0] lo;
    hi = 8'h00;
    lo = 8'h00;
    for (int i = 0; i < 40 && baud_clk_o !== 1'b0; i++) step;
    for (int i = 0; i < 40 && baud_clk_o !== 1'b1; i++) step;
    while (baud_clk_o === 1'b1 && hi < 8'h28) begin
      hi++;
      step;
    end
    while (baud_clk_o === 1'b0 && lo < 8'h28) begin
      lo++;
      step;
    end
    chk(hi, 8'h06);
    chk(lo, 8'h06);
    $display("t_baud done");
  endtask
  // manchester output is held bit xor baud, one cycle late: 4 baud toggles in 24 cycles
  task automatic t_tx;
    logic [7:0] n;
    n = 8'h00;
    mcu.send_byte({`OP_TX, 4'h0, `PATH_ASYNC});
    mcu.send_byte(8'hFF);
    chk(tx_data_o, 1'b1);
    mcu.restart;
    mcu.send_byte({`OP_TX, 4'h0, `PATH_MANCH});
    mcu.send_byte(8'hFF);
    for (int i = 0; i < 24; i++) begin
      step;
      n = n + (tx_data_o ^ baud_clk_o);
    end
    chk(n, 8'h14);
    mcu.restart;
    $display("t_tx done");
  endtask
  task automatic t_pll;
    for (logic [1:0] d = 2'h0; d < 2'h3; d++) begin
      wr(`ADDR_CFG, {3'h0, d, 1'b1, 2'h1});
      step;
      chk({vco_div_o, mash3_o}, {5'h0, d, 1'b1});
    end
    wr(`ADDR_PLL, 8'h2B);
    pll_lock_i <= 1'b1;
    for (int i = 0; i < 1500 && pll_locked_o !== 1'b1; i++) step;
    chk({pll_locked_o, pa_on_o, auto_band_select_o}, 8'h3F);
    rd_chk(`ADDR_BAND, 8'h0F);
    chk(charge_pump_o, 4'hA);
    @(posedge sys_clk_i);
    supply_low_i <= 1'b1;
    repeat (8) step;
    chk(pa_on_o, 1'b0);
    @(posedge sys_clk_i);
    supply_low_i <= 1'b0;
    pll_lock_i <= 1'b0;
    temp_adc_i <= 10'h2A5;
    wr(`ADDR_PLL, 8'h00);
    repeat (8) step;
    rd_chk(`ADDR_TEMP_LO, 8'hA5);
    rd_chk(`ADDR_TEMP_HI, 8'h02);
    $display("t_pll done");
  endtask
  task automatic t_pd;
    mcu.stop;
    repeat (40) step;
    chk(power_down_o, 1'b0);
    repeat (40) step;
    chk({power_down_o, osc_start_o}, 8'h02);
    mcu.wake(1'b1, 1'b0);
    for (int i = 0; i < 80 && osc_ready_o !== 1'b1; i++) step;
    rd_chk(`ADDR_STATUS, 8'h60);
    repeat (4) step;
    chk(host_clock_out_o, 1'b0);
    $display("t_pd done");
  endtask
  task automatic test_done;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // roughly 2800 cycles expected; allow more than ten times that
  initial begin
    #400000;
    mismatches++;
    test_done;
  end
  initial begin
    repeat (12) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    t_reset;
    t_wake;
    t_serial;
    t_baud;
    t_tx;
    t_pll;
    t_pd;
    test_done;
  end
endmodule
